// ===== logic/mft_cfg.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
// Operation
// - The transmit near-capacity level minus 3 is the stream ready latency, legal from 3 to 11, so at most 8.
// - In the reduced variant the levels and gap are read-only at 16, depth minus 16, 8, 3 and 12.
// - Each management slot keeps a 5-bit PHY address in its low bits and reads zero above.
// - With flow control on, pause requests are spaced by the 16-bit holdoff count, which resets to all ones.
// - The gap in force is the programmed value when it lies in 8 to 26, else 12, while readback shows the written value.
// - Gap register bits above bit 4 read zero and ignore writes.
// - A software reset clears only the transmit and receive enable bits, loads the flow control bit from the written word and leaves all other settings.
module mft_cfg #(
	parameter int LVL_W = 16,
	parameter int FIFO_DEPTH = 2048,
	parameter bit SMALL_MAC = 1'b0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Datapath fill levels
	input wire logic [LVL_W-1:0] rx_fill_level,
	input wire logic [LVL_W-1:0] tx_fill_level,
	// Pause request side
	input wire logic xoff_request,
	input wire logic quanta_tick,
	output logic xoff_send,
	// Threshold indications
	output logic rx_start_ok,
	output logic rx_near_empty,
	output logic rx_near_full,
	output logic tx_start_ok,
	output logic tx_partial_empty,
	output logic tx_near_empty,
	output logic tx_near_full,
	// Settings in force
	output logic transmit_enable_bit,
	output logic receive_enable_bit,
	output logic [4:0] phy_address_space_zero,
	output logic [4:0] phy_address_space_one,
	output logic [4:0] ipg_bytes,
	output logic [3:0] ready_latency
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic flow_en;
		logic [LVL_W-1:0] rx_fwd;
		logic [LVL_W-1:0] tx_pe;
		logic [LVL_W-1:0] tx_fwd;
		logic [LVL_W-1:0] rx_nd;
		logic [LVL_W-1:0] rx_nc;
		logic [LVL_W-1:0] tx_nd;
		logic [LVL_W-1:0] tx_nc;
		logic [4:0] phy0;
		logic [4:0] phy1;
		logic [15:0] hold;
		logic [4:0] ipg;
		logic [15:0] hold_cnt;
		logic xoff;
		logic ack;
		logic [31:0] rdat;
	} mft_state_t;

	localparam mft_state_t ST_RST = '{
		rx_fwd: LVL_W'(mft_pkg::RST_LEVEL),
		tx_pe: LVL_W'(mft_pkg::RST_LEVEL),
		tx_fwd: LVL_W'(mft_pkg::RST_LEVEL),
		rx_nd: LVL_W'(mft_pkg::RST_LEVEL),
		rx_nc: LVL_W'(mft_pkg::RST_LEVEL),
		tx_nd: LVL_W'(mft_pkg::RST_LEVEL),
		tx_nc: LVL_W'(mft_pkg::RST_LEVEL),
		phy0: mft_pkg::RST_PHY0,
		phy1: mft_pkg::RST_PHY1,
		hold: mft_pkg::RST_HOLD,
		ipg: mft_pkg::RST_IPG,
		default: '0
	};

	localparam logic [LVL_W-1:0] FWD_FIX = LVL_W'(mft_pkg::FIX_FWD);
	localparam logic [LVL_W-1:0] PE_FIX = LVL_W'(FIFO_DEPTH - int'(mft_pkg::FIX_PE_MARGIN));
	localparam logic [LVL_W-1:0] NEAR_FIX = LVL_W'(mft_pkg::FIX_NEAR);
	localparam logic [LVL_W-1:0] TXNC_FIX = LVL_W'(mft_pkg::FIX_TX_NC);
	localparam logic [LVL_W-1:0] NC_LO = LVL_W'(mft_pkg::NC_BASE);
	localparam logic [LVL_W-1:0] NC_HI = LVL_W'(mft_pkg::NC_MAX);

	mft_state_t st_r;
	mft_state_t st_nxt;

	logic req;
	logic commit;
	logic [7:0] idx;
	logic [31:0] rd_val;
	logic [31:0] ctrl_val;
	logic [31:0] stat_val;
	logic ipg_ok;
	logic [LVL_W-1:0] eff_rx_fwd;
	logic [LVL_W-1:0] eff_tx_pe;
	logic [LVL_W-1:0] eff_tx_fwd;
	logic [LVL_W-1:0] eff_rx_nd;
	logic [LVL_W-1:0] eff_rx_nc;
	logic [LVL_W-1:0] eff_tx_nd;
	logic [LVL_W-1:0] eff_tx_nc;

	function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// Values in force
	// ****************************************
	// Reduced variant ignores stored levels entirely
	assign eff_rx_fwd = SMALL_MAC ? FWD_FIX : st_r.rx_fwd;
	assign eff_tx_pe = SMALL_MAC ? PE_FIX : st_r.tx_pe;
	assign eff_tx_fwd = SMALL_MAC ? FWD_FIX : st_r.tx_fwd;
	assign eff_rx_nd = SMALL_MAC ? NEAR_FIX : st_r.rx_nd;
	assign eff_rx_nc = SMALL_MAC ? NEAR_FIX : st_r.rx_nc;
	assign eff_tx_nd = SMALL_MAC ? NEAR_FIX : st_r.tx_nd;
	assign eff_tx_nc = SMALL_MAC ? TXNC_FIX : st_r.tx_nc;

	assign ipg_ok = (st_r.ipg >= mft_pkg::IPG_MIN) && (st_r.ipg <= mft_pkg::IPG_MAX);

	always_comb begin
		if (SMALL_MAC) begin
			ipg_bytes = mft_pkg::FIX_IPG;
		end else if (ipg_ok) begin
			ipg_bytes = st_r.ipg;
		end else begin
			ipg_bytes = mft_pkg::IPG_DFLT;
		end
	end

	// Out-of-range settings are clamped so the stream never sees a bad latency
	always_comb begin
		if (eff_tx_nc < NC_LO) begin
			ready_latency = 4'h0;
		end else if (eff_tx_nc > NC_HI) begin
			ready_latency = mft_pkg::RDY_LAT_MAX;
		end else begin
			ready_latency = 4'(eff_tx_nc - NC_LO);
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	assign idx = {2'h0, wb_adr_i[7:2]};

	always_comb begin
		ctrl_val = '0;
		ctrl_val[mft_pkg::CTRL_TX_EN_BIT] = st_r.tx_en;
		ctrl_val[mft_pkg::CTRL_RX_EN_BIT] = st_r.rx_en;
		ctrl_val[mft_pkg::CTRL_FLOW_BIT] = st_r.flow_en;
		stat_val = '0;
		stat_val[mft_pkg::STAT_RX_LSB +: 4] = {rx_near_full, rx_near_empty, 1'b0, rx_start_ok};
		stat_val[mft_pkg::STAT_TX_LSB +: 4] = {tx_near_full, tx_near_empty, tx_partial_empty,
			tx_start_ok};
		stat_val[mft_pkg::STAT_HOLD_BIT] = st_r.hold_cnt != 16'h0000;
		stat_val[mft_pkg::STAT_IPG_BAD_BIT] = ~ipg_ok;
	end

	always_comb begin
		case (idx)
			mft_pkg::IDX_CTRL: rd_val = ctrl_val;
			mft_pkg::IDX_RX_FWD: rd_val = 32'(eff_rx_fwd);
			mft_pkg::IDX_TX_PE: rd_val = 32'(eff_tx_pe);
			mft_pkg::IDX_TX_FWD: rd_val = 32'(eff_tx_fwd);
			mft_pkg::IDX_RX_ND: rd_val = 32'(eff_rx_nd);
			mft_pkg::IDX_RX_NC: rd_val = 32'(eff_rx_nc);
			mft_pkg::IDX_TX_ND: rd_val = 32'(eff_tx_nd);
			mft_pkg::IDX_TX_NC: rd_val = 32'(eff_tx_nc);
			mft_pkg::IDX_PHY0: rd_val = 32'(st_r.phy0);
			mft_pkg::IDX_PHY1: rd_val = 32'(st_r.phy1);
			mft_pkg::IDX_HOLD: rd_val = 32'(st_r.hold);
			mft_pkg::IDX_IPG: rd_val = 32'(SMALL_MAC ? mft_pkg::FIX_IPG : st_r.ipg);
			mft_pkg::IDX_STAT: rd_val = stat_val;
			default: rd_val = '0;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	assign req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign commit = req & st_r.ack;

	always_comb begin
		logic [31:0] w;
		w = '0;
		st_nxt = st_r;
		st_nxt.ack = req & ~st_r.ack;
		st_nxt.xoff = 1'b0;
		if (req & ~st_r.ack) begin
			st_nxt.rdat = rd_val;
		end
		if (commit & wb_we_i) begin
			w = mrg(rd_val, wb_dat_i, wb_sel_i);
			case (idx)
				mft_pkg::IDX_CTRL: begin
					st_nxt.flow_en = w[mft_pkg::CTRL_FLOW_BIT];
					if (w[mft_pkg::CTRL_SWRST_BIT]) begin
						st_nxt.tx_en = 1'b0;
						st_nxt.rx_en = 1'b0;
					end else begin
						st_nxt.tx_en = w[mft_pkg::CTRL_TX_EN_BIT];
						st_nxt.rx_en = w[mft_pkg::CTRL_RX_EN_BIT];
					end
				end
				mft_pkg::IDX_RX_FWD: if (!SMALL_MAC) st_nxt.rx_fwd = w[LVL_W-1:0];
				mft_pkg::IDX_TX_PE: if (!SMALL_MAC) st_nxt.tx_pe = w[LVL_W-1:0];
				mft_pkg::IDX_TX_FWD: if (!SMALL_MAC) st_nxt.tx_fwd = w[LVL_W-1:0];
				mft_pkg::IDX_RX_ND: if (!SMALL_MAC) st_nxt.rx_nd = w[LVL_W-1:0];
				mft_pkg::IDX_RX_NC: if (!SMALL_MAC) st_nxt.rx_nc = w[LVL_W-1:0];
				mft_pkg::IDX_TX_ND: if (!SMALL_MAC) st_nxt.tx_nd = w[LVL_W-1:0];
				mft_pkg::IDX_TX_NC: if (!SMALL_MAC) st_nxt.tx_nc = w[LVL_W-1:0];
				mft_pkg::IDX_PHY0: st_nxt.phy0 = w[4:0];
				mft_pkg::IDX_PHY1: st_nxt.phy1 = w[4:0];
				mft_pkg::IDX_HOLD: st_nxt.hold = w[15:0];
				mft_pkg::IDX_IPG: if (!SMALL_MAC) st_nxt.ipg = w[4:0];
				default: ;
			endcase
		end
		// Holdoff spacing; the reduced variant has no flow control
		if (st_r.hold_cnt != 16'h0000 && quanta_tick) begin
			st_nxt.hold_cnt = st_r.hold_cnt - 16'h0001;
		end
		if (!SMALL_MAC && xoff_request && st_r.flow_en && st_r.tx_en &&
			st_r.hold_cnt == 16'h0000) begin
			st_nxt.xoff = 1'b1;
			st_nxt.hold_cnt = st_r.hold;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs and comparators
	// ****************************************
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdat;
	assign xoff_send = st_r.xoff;
	assign transmit_enable_bit = st_r.tx_en;
	assign receive_enable_bit = st_r.rx_en;
	assign phy_address_space_zero = st_r.phy0;
	assign phy_address_space_one = st_r.phy1;

	mft_level_cmp #(.LVL_W(LVL_W), .FIFO_DEPTH(FIFO_DEPTH)) u_rx_cmp (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fill(rx_fill_level),
		.start_lvl(eff_rx_fwd),
		.pe_lvl(PE_FIX),
		.nd_lvl(eff_rx_nd),
		.nc_lvl(eff_rx_nc),
		.start_ok(rx_start_ok),
		.pe_hit(),
		.near_empty(rx_near_empty),
		.near_full(rx_near_full)
	);

	mft_level_cmp #(.LVL_W(LVL_W), .FIFO_DEPTH(FIFO_DEPTH)) u_tx_cmp (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fill(tx_fill_level),
		.start_lvl(eff_tx_fwd),
		.pe_lvl(eff_tx_pe),
		.nd_lvl(eff_tx_nd),
		.nc_lvl(eff_tx_nc),
		.start_ok(tx_start_ok),
		.pe_hit(tx_partial_empty),
		.near_empty(tx_near_empty),
		.near_full(tx_near_full)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

	property p_rdy_lat;
		(eff_tx_nc >= NC_LO && eff_tx_nc <= NC_HI) |-> ready_latency == 4'(eff_tx_nc - NC_LO)
			&& ready_latency <= mft_pkg::RDY_LAT_MAX;
	endproperty
	a_rdy_lat: assert property (p_rdy_lat) else $error("ready latency wrong");

	property p_small_ipg_read;
		(SMALL_MAC && req && !wb_ack_o && idx == mft_pkg::IDX_IPG)
			|=> wb_dat_o == 32'(mft_pkg::FIX_IPG);
	endproperty
	a_small_ipg_read: assert property (p_small_ipg_read) else $error("fixed gap not read");

	property p_phy_read;
		(req && !wb_ack_o && idx == mft_pkg::IDX_PHY1)
			|=> wb_dat_o[31:5] == 27'h0 && wb_dat_o[4:0] == $past(st_r.phy1);
	endproperty
	a_phy_read: assert property (p_phy_read) else $error("PHY slot read wrong");

	property p_xoff_space;
		xoff_send |-> st_r.hold_cnt == $past(st_r.hold)
			##1 (!xoff_send || $past(st_r.hold, 2) == 16'h0);
	endproperty
	a_xoff_space: assert property (p_xoff_space) else $error("pause requests too close");

	property p_ipg_force;
		(!SMALL_MAC && !ipg_ok) |-> ipg_bytes == mft_pkg::IPG_DFLT;
	endproperty
	a_ipg_force: assert property (p_ipg_force) else $error("bad gap not replaced");

	property p_ipg_write;
		(!SMALL_MAC && commit && wb_we_i && wb_sel_i[0] && idx == mft_pkg::IDX_IPG)
			|=> st_r.ipg == 5'($past(wb_dat_i));
	endproperty
	a_ipg_write: assert property (p_ipg_write) else $error("gap write lost");

	property p_swrst;
		(commit && wb_we_i && wb_sel_i[1] && idx == mft_pkg::IDX_CTRL &&
			wb_dat_i[mft_pkg::CTRL_SWRST_BIT])
			|=> !transmit_enable_bit && !receive_enable_bit && $stable(st_r.phy0)
			&& $stable(st_r.hold);
	endproperty
	a_swrst: assert property (p_swrst) else $error("software reset wrong");
endmodule

// ===== pkg/mft_pkg.sv
package mft_pkg;
	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_CTRL = 8'h02;
	localparam logic [7:0] IDX_RX_FWD = 8'h08;
	localparam logic [7:0] IDX_TX_PE = 8'h09;
	localparam logic [7:0] IDX_TX_FWD = 8'h0a;
	localparam logic [7:0] IDX_RX_ND = 8'h0b;
	localparam logic [7:0] IDX_RX_NC = 8'h0c;
	localparam logic [7:0] IDX_TX_ND = 8'h0d;
	localparam logic [7:0] IDX_TX_NC = 8'h0e;
	localparam logic [7:0] IDX_PHY0 = 8'h0f;
	localparam logic [7:0] IDX_PHY1 = 8'h10;
	localparam logic [7:0] IDX_HOLD = 8'h11;
	localparam logic [7:0] IDX_IPG = 8'h17;
	localparam logic [7:0] IDX_STAT = 8'h18;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_RX_EN_BIT = 1;
	localparam int CTRL_FLOW_BIT = 2;
	localparam int CTRL_SWRST_BIT = 13;

	// ****************************************
	// Status register fields
	// ****************************************
	localparam int STAT_RX_LSB = 0;
	localparam int STAT_TX_LSB = 4;
	localparam int STAT_HOLD_BIT = 8;
	localparam int STAT_IPG_BAD_BIT = 9;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_LEVEL = 16'h0000;
	localparam logic [4:0] RST_PHY0 = 5'h00;
	localparam logic [4:0] RST_PHY1 = 5'h01;
	localparam logic [15:0] RST_HOLD = 16'hffff;
	localparam logic [4:0] RST_IPG = 5'h00;

	// ****************************************
	// Fixed values of the reduced variant
	// ****************************************
	localparam logic [15:0] FIX_FWD = 16'h0010;
	localparam logic [15:0] FIX_PE_MARGIN = 16'h0010;
	localparam logic [15:0] FIX_NEAR = 16'h0008;
	localparam logic [15:0] FIX_TX_NC = 16'h0003;
	localparam logic [4:0] FIX_IPG = 5'h0c;

	// ****************************************
	// Gap and ready-latency limits
	// ****************************************
	localparam logic [4:0] IPG_MIN = 5'h08;
	localparam logic [4:0] IPG_MAX = 5'h1a;
	localparam logic [4:0] IPG_DFLT = 5'h0c;
	localparam logic [15:0] NC_BASE = 16'h0003;
	localparam logic [15:0] NC_MAX = 16'h000b;
	localparam logic [3:0] RDY_LAT_MAX = 4'h8;
endpackage

// ===== logic/mft_level_cmp.sv
`timescale 1ns/100ps
module mft_level_cmp #(
	parameter int LVL_W = 16,
	parameter int FIFO_DEPTH = 2048
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Fill level and thresholds
	input wire logic [LVL_W-1:0] fill,
	input wire logic [LVL_W-1:0] start_lvl,
	input wire logic [LVL_W-1:0] pe_lvl,
	input wire logic [LVL_W-1:0] nd_lvl,
	input wire logic [LVL_W-1:0] nc_lvl,
	// Indications
	output logic start_ok,
	output logic pe_hit,
	output logic near_empty,
	output logic near_full
);
	typedef struct packed {
		logic start_ok;
		logic pe_hit;
		logic near_empty;
		logic near_full;
	} mft_cmp_t;

	localparam logic [LVL_W:0] DEPTH_W = (LVL_W+1)'(FIFO_DEPTH);

	mft_cmp_t st_r;
	mft_cmp_t st_nxt;

	// Zero start level means store-and-forward: never start early
	always_comb begin
		st_nxt.start_ok = (start_lvl != '0) && (fill >= start_lvl);
		st_nxt.pe_hit = fill >= pe_lvl;
		st_nxt.near_empty = fill <= nd_lvl;
		// Widened sum avoids wrap when fill plus margin overflows LVL_W bits
		st_nxt.near_full = ({1'b0, fill} + {1'b0, nc_lvl}) >= DEPTH_W;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign start_ok = st_r.start_ok;
	assign pe_hit = st_r.pe_hit;
	assign near_empty = st_r.near_empty;
	assign near_full = st_r.near_full;

	property p_near_track;
		@(posedge sys_clk) disable iff (!rst_n)
		(fill <= nd_lvl) ##1 $stable(fill) && $stable(nd_lvl) |=> near_empty;
	endproperty
	a_near_track: assert property (p_near_track) else $error("near-empty not raised");
endmodule

// ===== verif/mft_dp_model.sv
`timescale 1ns/100ps
module mft_dp_model #(
	parameter int TICK_DIV = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pause quanta
	input wire logic tick_en,
	output logic quanta_tick
);
	logic [7:0] cnt;
	// Ticks stop while disabled, so no stale quantum leaks into the next test
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !tick_en) begin
			cnt <= 8'h00;
			quanta_tick <= 1'b0;
		end else begin
			quanta_tick <= (cnt == 8'(TICK_DIV - 1));
			cnt <= (cnt == 8'(TICK_DIV - 1)) ? 8'h00 : cnt + 8'h01;
		end
	end
endmodule

// ===== verif/mft_cfg_test.sv
`timescale 1ns/100ps
module mft_cfg_test;
	localparam int DEPTH = 2048;
	logic sys_clk = 1'b0, rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, s_dat, q;
	logic wb_ack_o, xoff_request = 1'b0, quanta_tick, xoff_send, tick_en = 1'b0;
	logic [15:0] rx_fill_level = 16'h0, tx_fill_level = 16'h0;
	logic [6:0] ind;
	logic transmit_enable_bit, receive_enable_bit;
	logic [4:0] phy_address_space_zero, phy_address_space_one, ipg_bytes;
	logic [3:0] ready_latency;
	int num_errors = 0, tests_run = 0;
	logic [7:0] ridx [12] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h17,
		8'h0f, 8'h10, 8'h11, 8'h12};
	logic [31:0] rnorm [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h1, 32'hffff, 0};
	logic [31:0] rsml [8] = '{32'h10, 32'(DEPTH - 16), 32'h10, 32'h8, 32'h8, 32'h8, 32'h3, 32'hc};

	always #10 sys_clk = ~sys_clk;

	mft_dp_model #(.TICK_DIV(3)) i_mft_dp_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.tick_en(tick_en), .quanta_tick(quanta_tick));

	mft_cfg #(.LVL_W(16), .FIFO_DEPTH(DEPTH), .SMALL_MAC(1'b0)) i_mft_cfg (
		.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_fill_level(rx_fill_level),
		.tx_fill_level(tx_fill_level), .xoff_request(xoff_request), .quanta_tick(quanta_tick),
		.xoff_send(xoff_send), .rx_start_ok(ind[6]), .rx_near_empty(ind[5]),
		.rx_near_full(ind[4]), .tx_start_ok(ind[3]), .tx_partial_empty(ind[2]),
		.tx_near_empty(ind[1]), .tx_near_full(ind[0]),
		.transmit_enable_bit(transmit_enable_bit), .receive_enable_bit(receive_enable_bit),
		.phy_address_space_zero(phy_address_space_zero),
		.phy_address_space_one(phy_address_space_one), .ipg_bytes(ipg_bytes),
		.ready_latency(ready_latency));

	// Reduced variant shares the bus; its ack matches the main one cycle for cycle
	mft_cfg #(.LVL_W(16), .FIFO_DEPTH(DEPTH), .SMALL_MAC(1'b1)) i_mft_cfg_small (
		.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(s_dat), .wb_ack_o(), .rx_fill_level(rx_fill_level),
		.tx_fill_level(tx_fill_level), .xoff_request(xoff_request), .quanta_tick(quanta_tick),
		.xoff_send(), .rx_start_ok(), .rx_near_empty(), .rx_near_full(), .tx_start_ok(),
		.tx_partial_empty(), .tx_near_empty(), .tx_near_full(), .transmit_enable_bit(),
		.receive_enable_bit(), .phy_address_space_zero(), .phy_address_space_one(),
		.ipg_bytes(), .ready_latency());

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] be,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx[5:0], 2'b00};
		wb_sel_i <= be;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			num_errors++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, 4'hf, d);
	endtask

	task automatic rd(input logic [7:0] idx);
		xfer(1'b0, idx, 4'hf, 32'h0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic sc_reset_values();
		for (int k = 0; k < 12; k++) begin
			rd(ridx[k]);
			chk("reset value", q, rnorm[k]);
			if (k < 8) chk("small fixed value", s_dat, rsml[k]);
		end
		chk("ipg in force at reset", 32'(ipg_bytes), 32'hc);
	endtask

	task automatic sc_fields();
		logic [31:0] gw [5] = '{32'hffffffff, 32'h8, 32'h1a, 32'h7, 32'h1b};
		logic [31:0] gf [5] = '{32'hc, 32'h8, 32'h1a, 32'hc, 32'hc};
		wr(8'h08, 32'hffffffff);
		rd(8'h08);
		chk("level width", q, 32'hffff);
		chk("small level ignores write", s_dat, 32'h10);
		wr(8'h0f, 32'hffffffff);
		rd(8'h0f);
		chk("phy slot zero", q, 32'h1f);
		@(posedge sys_clk);
		chk("phy slot zero port", 32'(phy_address_space_zero), 32'h1f);
		wr(8'h10, 32'h25);
		rd(8'h10);
		chk("phy slot one", q, 32'h5);
		chk("phy slot one port", 32'(phy_address_space_one), 32'h5);
		wr(8'h12, 32'hffffffff);
		rd(8'h12);
		chk("reserved reads zero", q, 32'h0);
		xfer(1'b1, 8'h11, 4'h1, 32'h12345678);
		rd(8'h11);
		chk("holdoff byte merge", q, 32'hff78);
		for (int k = 0; k < 5; k++) begin
			wr(8'h17, gw[k]);
			rd(8'h17);
			chk("gap readback", q, gw[k] & 32'h1f);
			chk("gap in force", 32'(ipg_bytes), gf[k]);
		end
		// Ends of the loop reach the clamp on both sides
		for (int v = 2; v <= 12; v++) begin
			wr(8'h0e, 32'(v));
			@(posedge sys_clk);
			chk("ready latency", 32'(ready_latency), 32'((v < 3) ? 0 : ((v > 11) ? 8 : v - 3)));
		end
	endtask

	task automatic sc_levels();
		logic [15:0] rf [5] = '{16'd4, 16'd16, 16'd2040, 16'd2039, 16'd8};
		logic [15:0] tf [5] = '{16'd4, 16'd16, 16'd2032, 16'd2045, 16'd2044};
		logic [6:0] ex [5] = '{7'b0100010, 7'b1001000, 7'b1011100, 7'b1001101, 7'b0101100};
		wr(8'h08, 32'd16);
		wr(8'h0a, 32'd16);
		wr(8'h09, 32'(DEPTH - 16));
		wr(8'h0b, 32'd8);
		wr(8'h0c, 32'd8);
		wr(8'h0d, 32'd8);
		wr(8'h0e, 32'd3);
		for (int k = 0; k < 5; k++) begin
			@(posedge sys_clk);
			rx_fill_level <= rf[k];
			tx_fill_level <= tf[k];
			repeat (3) @(posedge sys_clk);
			chk("indications", 32'(ind), 32'(ex[k]));
		end
		// Last fills: rx near-drain, tx start and partial-empty; gap left out of range
		rd(8'h18);
		chk("status word", q, 32'h234);
	endtask

	task automatic sc_soft_reset();
		wr(8'h02, 32'h7);
		@(posedge sys_clk);
		chk("enables set", 32'({transmit_enable_bit, receive_enable_bit}), 32'h3);
		wr(8'h02, 32'h2004);
		@(posedge sys_clk);
		chk("enables cleared", 32'({transmit_enable_bit, receive_enable_bit}), 32'h0);
		rd(8'h08);
		chk("level kept", q, 32'd16);
		rd(8'h0f);
		chk("phy slot kept", q, 32'h1f);
	endtask

	task automatic sc_pause();
		int n;
		int cnt;
		wr(8'h11, 32'h4);
		wr(8'h02, 32'h5);
		tick_en <= 1'b1;
		xoff_request <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (xoff_send !== 1'b1 && n < 40);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (xoff_send !== 1'b1 && n < 100);
		// Four quanta of three cycles each, plus request and answer cycles
		chk("pause spacing ok", 32'(n >= 12 && n <= 18), 32'h1);
		wr(8'h02, 32'h1);
		cnt = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (xoff_send === 1'b1) cnt++;
		end
		chk("no pause without flow control", 32'(cnt), 32'h0);
		xoff_request <= 1'b0;
		tick_en <= 1'b0;
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		sc_reset_values();
		sc_fields();
		sc_levels();
		sc_soft_reset();
		sc_pause();
		print_verdict();
	end
endmodule
